// >>> jtp_host.sv
// behavioural serial test controller at the far side of the port
`default_nettype none
module jtp_host (
	input wire logic clk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 1ps;
	logic q_x;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one 320 ns test clock: five cycles low, three high
	task automatic bit_io(input logic m, input logic d, output logic q);
		@(posedge clk);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge clk);
		@(negedge clk);
		q = tdo; // read late in the low phase, well after the data moved
		@(posedge clk);
		tck <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	// five rises with mode select high reach reset from any state
	task automatic to_reset();
		repeat (5) bit_io(1'b1, 1'b0, q_x);
		bit_io(1'b0, 1'b0, q_x);
	endtask
	task automatic idle(input int n);
		repeat (n) bit_io(1'b0, 1'b0, q_x);
	endtask
	// scan of n bits from idle, pausing after bit p, ending in idle
	task automatic scan(input logic is_ir, input int n, input int p,
		input logic [127:0] din, output logic [127:0] dout);
		int i;
		int k;
		dout = '0;
		bit_io(1'b1, 1'b0, q_x);
		if (is_ir)
			bit_io(1'b1, 1'b0, q_x);
		bit_io(1'b0, 1'b0, q_x);
		bit_io(1'b0, 1'b0, q_x);
		for (i = 0; i < n; i++) begin
			bit_io(i == n - 1 || i == p, din[i], dout[i]);
			if (i == p && i != n - 1)
				for (k = 0; k < 4; k++) bit_io(k == 2, 1'b0, q_x);
		end
		bit_io(1'b1, 1'b0, q_x);
		bit_io(1'b0, 1'b0, q_x);
	endtask
endmodule
`default_nettype wire

// >>> jtp_map.vh
// constants for the test access port: instruction codes, widths and timing
`ifndef JTP_MAP_VH
`define JTP_MAP_VH

// tap controller states, one-hot
`define JTP_ST_W 16
`define JTP_TLR  16'h0001
`define JTP_RTI  16'h0002
`define JTP_SDRS 16'h0004
`define JTP_CDR  16'h0008
`define JTP_SDR  16'h0010
`define JTP_E1DR 16'h0020
`define JTP_PDR  16'h0040
`define JTP_E2DR 16'h0080
`define JTP_UDR  16'h0100
`define JTP_SIRS 16'h0200
`define JTP_CIR  16'h0400
`define JTP_SIR  16'h0800
`define JTP_E1IR 16'h1000
`define JTP_PIR  16'h2000
`define JTP_E2IR 16'h4000
`define JTP_UIR  16'h8000

// instruction codes, eight bits
`define JTP_IR_W          8
`define JTP_OP_EXTEST     8'h00
`define JTP_OP_ADDR       8'h01
`define JTP_OP_DATA       8'h02
`define JTP_OP_ERASE      8'h03
`define JTP_OP_PROG       8'h07
`define JTP_OP_PROG_LOCK  8'h09
`define JTP_OP_VERIFY     8'h0A
`define JTP_OP_PEN        8'h15
`define JTP_OP_IDENT      8'h16
`define JTP_OP_USIG       8'h17
`define JTP_OP_PROG_USIG  8'h1A
`define JTP_OP_SAMPLE     8'h1C
`define JTP_OP_PDIS       8'h1E
`define JTP_OP_HIGHZ      8'h18
`define JTP_OP_PROG_INCR  8'h27
`define JTP_OP_VERI_INCR  8'h2A

// data path widths
`define JTP_ADDR_W 10
`define JTP_COL_W  90
`define JTP_SIG_W  32
`define JTP_BSR_W  8
`define JTP_IDENT_W 32

// store operation time in cycles of clk
`define JTP_OP_CYC 8

`endif

// >>> jtp_nvm.v
// non-volatile configuration store model: columns, signature and lock
`default_nettype none
module jtp_nvm #(
	parameter ADDR_W = 10,
	parameter COL_W = 90,
	parameter DEPTH = 16,
	parameter OP_CYC = 8
) (
	input wire clk,
	input wire rst,
	input wire start,
	input wire [2:0] op,
	input wire [ADDR_W-1:0] addr,
	input wire [COL_W-1:0] wdata,
	input wire [31:0] sig_wdata,
	output reg [COL_W-1:0] rdata_reg,
	output reg [31:0] sig_reg,
	output reg lock_reg,
	output wire busy
);
	// op encodings: 0 erase, 1 program, 2 lock, 3 verify, 4 signature
	localparam [2:0] OP_ERASE = 3'h0;
	localparam [2:0] OP_PROG = 3'h1;
	localparam [2:0] OP_LOCK = 3'h2;
	localparam [2:0] OP_VER = 3'h3;
	localparam [2:0] OP_SIG = 3'h4;

	reg [COL_W-1:0] mem [0:DEPTH-1];
	reg [7:0] cnt_reg;
	reg [2:0] op_reg;
	reg [ADDR_W-1:0] addr_reg;
	integer i;

	assign busy = (cnt_reg != 8'h00);

	// columns outside the modelled depth wrap; cells erase to zero
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 8'h00;
			op_reg <= 3'h0;
			addr_reg <= {ADDR_W{1'b0}};
			rdata_reg <= {COL_W{1'b0}};
			sig_reg <= 32'h00000000;
			lock_reg <= 1'b0;
		end else if (start && !busy) begin
			cnt_reg <= OP_CYC[7:0];
			op_reg <= op;
			addr_reg <= addr;
			if (op == OP_PROG)
				mem[addr % DEPTH] <= wdata;
			if (op == OP_SIG)
				sig_reg <= sig_wdata;
			if (op == OP_LOCK)
				lock_reg <= 1'b1;
			if (op == OP_ERASE) begin
				for (i = 0; i < DEPTH; i = i + 1)
					mem[i] <= {COL_W{1'b0}};
				sig_reg <= 32'h00000000;
				lock_reg <= 1'b0; // lock clears only by full erase or by reset
			end
		end else if (busy) begin
			cnt_reg <= cnt_reg - 8'h01;
			if (cnt_reg == 8'h01 && op_reg == OP_VER)
				rdata_reg <= mem[addr_reg % DEPTH];
		end
	end
endmodule
`default_nettype wire

// >>> jtp_tap.v
// boundary-scan test access port with configuration programming path
`default_nettype none
`include "jtp_map.vh"
module jtp_tap #(
	parameter [31:0] IDENT_CODE = 32'h00000001, // arbitrary value
	parameter DEPTH = 16
) (
	input wire clk,
	input wire rst,
	input wire tck,
	input wire tms,
	input wire tdi,
	output reg tdo_reg,
	output reg tdo_oe_n_reg,
	input wire [`JTP_BSR_W-1:0] pins_in,
	output wire [`JTP_BSR_W-1:0] pins_out,
	output wire pins_test,
	output wire prog_mode,
	output wire store_busy
);
	// pin synchronisers; first stage read only by the second
	reg tck_s1_reg, tck_s2_reg, tck_d_reg;
	reg tms_s1_reg, tms_s2_reg, tdi_s1_reg, tdi_s2_reg;
	// the pins come from outside the clock domain like the test pins
	reg [`JTP_BSR_W-1:0] pins_s1_reg, pins_s2_reg;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tck_s1_reg <= 1'b0;
			tck_s2_reg <= 1'b0;
			tck_d_reg <= 1'b0;
			tms_s1_reg <= 1'b1;
			tms_s2_reg <= 1'b1;
			tdi_s1_reg <= 1'b0;
			tdi_s2_reg <= 1'b0;
			pins_s1_reg <= 8'h00;
			pins_s2_reg <= 8'h00;
		end else begin
			tck_s1_reg <= tck;
			tck_s2_reg <= tck_s1_reg;
			tck_d_reg <= tck_s2_reg;
			tms_s1_reg <= tms;
			tms_s2_reg <= tms_s1_reg;
			tdi_s1_reg <= tdi;
			tdi_s2_reg <= tdi_s1_reg;
			pins_s1_reg <= pins_in;
			pins_s2_reg <= pins_s1_reg;
		end
	end
	// tms and tdi pass the same two stages as tck, so they stay aligned
	// an edge is seen two to three clk after the pin moves, which is why
	// the test clock must stay at least three clk in each level
	wire rise = tck_s2_reg & ~tck_d_reg;
	wire fall = ~tck_s2_reg & tck_d_reg;
	wire tms_s = tms_s2_reg;
	wire tdi_s = tdi_s2_reg;

	reg [`JTP_ST_W-1:0] st_reg, st_next;
	reg [`JTP_IR_W-1:0] ir_reg, ir_sh_reg;
	reg [`JTP_ADDR_W-1:0] addr_reg;
	reg [`JTP_COL_W-1:0] col_reg;
	reg [`JTP_SIG_W-1:0] sig_sh_reg;
	reg [`JTP_BSR_W-1:0] bsr_reg, bsr_upd_reg;
	reg [31:0] dr_reg;
	reg byp_reg, pen_reg, pend_reg, start_reg, hiz_reg;
	reg [2:0] op_reg;
	wire [`JTP_COL_W-1:0] nvm_rdata;
	wire [31:0] nvm_sig;
	wire nvm_lock;

	// next state of the sixteen-state controller
	always @* begin
		case (st_reg)
		`JTP_TLR: st_next = tms_s ? `JTP_TLR : `JTP_RTI;
		`JTP_RTI: st_next = tms_s ? `JTP_SDRS : `JTP_RTI;
		// data column
		`JTP_SDRS: st_next = tms_s ? `JTP_SIRS : `JTP_CDR;
		`JTP_CDR: st_next = tms_s ? `JTP_E1DR : `JTP_SDR;
		`JTP_SDR: st_next = tms_s ? `JTP_E1DR : `JTP_SDR;
		`JTP_E1DR: st_next = tms_s ? `JTP_UDR : `JTP_PDR;
		`JTP_PDR: st_next = tms_s ? `JTP_E2DR : `JTP_PDR;
		`JTP_E2DR: st_next = tms_s ? `JTP_UDR : `JTP_SDR;
		`JTP_UDR: st_next = tms_s ? `JTP_SDRS : `JTP_RTI;
		// instruction column, reached only through select-DR-scan
		`JTP_SIRS: st_next = tms_s ? `JTP_TLR : `JTP_CIR;
		`JTP_CIR: st_next = tms_s ? `JTP_E1IR : `JTP_SIR;
		`JTP_SIR: st_next = tms_s ? `JTP_E1IR : `JTP_SIR;
		`JTP_E1IR: st_next = tms_s ? `JTP_UIR : `JTP_PIR;
		`JTP_PIR: st_next = tms_s ? `JTP_E2IR : `JTP_PIR;
		`JTP_E2IR: st_next = tms_s ? `JTP_UIR : `JTP_SIR;
		`JTP_UIR: st_next = tms_s ? `JTP_SDRS : `JTP_RTI;
		default: st_next = `JTP_TLR;
		endcase
	end

	// store selection decoded from the instruction shifter at update-IR
	function is_store;
		input [`JTP_IR_W-1:0] op;
		begin
			is_store = (op == `JTP_OP_ERASE) || (op == `JTP_OP_PROG) ||
				(op == `JTP_OP_PROG_LOCK) || (op == `JTP_OP_VERIFY) ||
				(op == `JTP_OP_PROG_INCR) || (op == `JTP_OP_VERI_INCR) ||
				(op == `JTP_OP_PROG_USIG);
		end
	endfunction

	// bit positions of the data path selections
	localparam [2:0] P_BYP = 3'h0;
	localparam [2:0] P_ID = 3'h1;
	localparam [2:0] P_USIG = 3'h2;
	localparam [2:0] P_ADDR = 3'h3;
	localparam [2:0] P_COL = 3'h4;
	localparam [2:0] P_BSR = 3'h5;

	// codes handed to the store; they must match its own decoding
	localparam [2:0] NVM_ERASE = 3'h0;
	localparam [2:0] NVM_PROG = 3'h1;
	localparam [2:0] NVM_LOCK = 3'h2;
	localparam [2:0] NVM_VER = 3'h3;
	localparam [2:0] NVM_SIG = 3'h4;

	// one bit per data path; codes below the top bit never overlap
	function [5:0] path_sel;
		input [`JTP_IR_W-1:0] op;
		begin
			path_sel = 6'h00;
			path_sel[P_BYP] = op[`JTP_IR_W-1];
			path_sel[P_ID] = (op == `JTP_OP_IDENT);
			path_sel[P_USIG] = (op == `JTP_OP_USIG) ||
				(op == `JTP_OP_PROG_USIG);
			path_sel[P_ADDR] = (op == `JTP_OP_ADDR);
			path_sel[P_COL] = (op == `JTP_OP_DATA) ||
				(op == `JTP_OP_VERIFY) || (op == `JTP_OP_VERI_INCR);
			path_sel[P_BSR] = (op == `JTP_OP_EXTEST) ||
				(op == `JTP_OP_SAMPLE);
		end
	endfunction

	// store operation for each store instruction; others fall to verify
	function [2:0] store_code;
		input [`JTP_IR_W-1:0] op;
		begin
			case (op)
			`JTP_OP_ERASE: store_code = NVM_ERASE; // only path to unlock
			`JTP_OP_PROG: store_code = NVM_PROG;
			`JTP_OP_PROG_INCR: store_code = NVM_PROG;
			`JTP_OP_PROG_LOCK: store_code = NVM_LOCK;
			`JTP_OP_PROG_USIG: store_code = NVM_SIG;
			default: store_code = NVM_VER;
			endcase
		end
	endfunction

	// selections decoded once from the held instruction
	wire [5:0] path = path_sel(ir_reg);
	wire sel_byp = path[P_BYP];
	wire sel_id = path[P_ID];
	wire sel_usig = path[P_USIG];
	wire sel_addr = path[P_ADDR];
	wire sel_col = path[P_COL];
	wire sel_bsr = path[P_BSR];

	// serial output bit of the selected path, lsb first
	reg so_bit;
	always @* begin
		// during shift-IR the instruction shifter owns data out
		if (st_reg == `JTP_SIR)
			so_bit = ir_sh_reg[0];
		else if (sel_byp)
			so_bit = byp_reg;
		else if (sel_addr)
			so_bit = addr_reg[0];
		else if (sel_col)
			so_bit = col_reg[0];
		else if (sel_usig)
			so_bit = sig_sh_reg[0];
		else if (sel_bsr)
			so_bit = bsr_reg[0];
		else if (sel_id)
			so_bit = dr_reg[0];
		else
			so_bit = byp_reg;
	end

	// controller, shift paths and instruction handling on tck rising
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= `JTP_TLR;
			ir_reg <= `JTP_OP_IDENT;
			ir_sh_reg <= 8'h00;
			addr_reg <= 10'h000;
			col_reg <= {`JTP_COL_W{1'b0}};
			sig_sh_reg <= 32'h00000000;
			bsr_reg <= 8'h00;
			bsr_upd_reg <= 8'h00;
			dr_reg <= 32'h00000000;
			byp_reg <= 1'b0;
			pen_reg <= 1'b0;
			pend_reg <= 1'b0;
			start_reg <= 1'b0;
			hiz_reg <= 1'b0;
			op_reg <= 3'h0;
		end else begin
			start_reg <= 1'b0;
			if (rise) begin
				st_reg <= st_next;
				case (st_reg)
				`JTP_RTI: begin
					// store operation fires once per instruction
					if (pend_reg) begin
						pend_reg <= 1'b0;
						start_reg <= 1'b1;
					end
				end
				`JTP_CDR: begin
					byp_reg <= 1'b0;
					dr_reg <= IDENT_CODE;
					bsr_reg <= pins_s2_reg;
					sig_sh_reg <= nvm_sig;
					// configuration bits read as zero once locked
					if (sel_col)
						col_reg <= nvm_lock ?
							{`JTP_COL_W{1'b0}} : nvm_rdata;
				end
				`JTP_SDR: begin
					if (sel_byp)
						byp_reg <= tdi_s;
					else if (sel_addr)
						addr_reg <= {tdi_s, addr_reg[`JTP_ADDR_W-1:1]};
					else if (sel_col)
						col_reg <= {tdi_s, col_reg[`JTP_COL_W-1:1]};
					else if (sel_usig)
						sig_sh_reg <= {tdi_s, sig_sh_reg[31:1]};
					else if (sel_bsr)
						bsr_reg <= {tdi_s, bsr_reg[`JTP_BSR_W-1:1]};
					else if (sel_id)
						dr_reg <= {tdi_s, dr_reg[31:1]};
					else
						byp_reg <= tdi_s;
				end
				`JTP_UDR: begin
					// the pin latch moves only here, never while shifting
					if (sel_bsr)
						bsr_upd_reg <= bsr_reg;
				end
				// the fixed capture pattern lets a host check the chain
				`JTP_CIR: ir_sh_reg <= `JTP_OP_IDENT;
				`JTP_SIR: ir_sh_reg <= {tdi_s, ir_sh_reg[7:1]};
				`JTP_UIR: begin
					ir_reg <= ir_sh_reg;
					// non-store instructions act here
					if (ir_sh_reg == `JTP_OP_PEN)
						pen_reg <= 1'b1;
					if (ir_sh_reg == `JTP_OP_PDIS)
						pen_reg <= 1'b0;
					hiz_reg <= (ir_sh_reg == `JTP_OP_HIGHZ);
					// refused unless programming mode is on
					pend_reg <= is_store(ir_sh_reg) && pen_reg;
					// the code waits here until the next entry into idle
					op_reg <= store_code(ir_sh_reg);
				end
				default: begin
				end
				endcase
				// clear on entry, so five high clocks suffice from anywhere
				if (st_next == `JTP_TLR) begin
					ir_reg <= `JTP_OP_IDENT;
					pen_reg <= 1'b0;
					pend_reg <= 1'b0;
					hiz_reg <= 1'b0;
				end
			end
			// address steps after an auto-increment operation begins;
			// the store has latched the old address at this same edge
			if (start_reg && (ir_reg == `JTP_OP_PROG_INCR ||
				ir_reg == `JTP_OP_VERI_INCR))
				addr_reg <= addr_reg + 10'h001;
		end
	end

	// data out is updated on tck falling, enabled only while shifting;
	// this leaves one and a half clk before the host samples late in the low phase
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tdo_reg <= 1'b0;
			tdo_oe_n_reg <= 1'b1;
		end else if (fall) begin
			tdo_reg <= so_bit;
			tdo_oe_n_reg <= ~(st_reg == `JTP_SDR || st_reg == `JTP_SIR);
		end
	end

	assign pins_out = bsr_upd_reg;
	assign pins_test = (ir_reg == `JTP_OP_EXTEST) | hiz_reg;
	assign prog_mode = pen_reg;

	// store holds the columns, signature and lock bit; it runs on clk and
	// an operation lasts 8 clk, as long as one whole test clock
	jtp_nvm #(
		.ADDR_W(`JTP_ADDR_W),
		.COL_W(`JTP_COL_W),
		.DEPTH(DEPTH),
		.OP_CYC(`JTP_OP_CYC)
	) u_nvm (
		.clk(clk),
		.rst(rst),
		.start(start_reg),
		.op(op_reg),
		.addr(addr_reg),
		.wdata(col_reg),
		.sig_wdata(sig_sh_reg),
		.rdata_reg(nvm_rdata),
		.sig_reg(nvm_sig),
		.lock_reg(nvm_lock),
		.busy(store_busy)
	);
endmodule
`default_nettype wire

// >>> jtp_tap_chk.sv
// assertions on the pins of the test access port
`default_nettype none
`include "jtp_map.vh"
module jtp_tap_chk (
	input wire clk,
	input wire rst,
	input wire tck,
	input wire tms,
	input wire tdi,
	input wire tdo_reg,
	input wire tdo_oe_n_reg,
	input wire [`JTP_BSR_W-1:0] pins_in,
	input wire [`JTP_BSR_W-1:0] pins_out,
	input wire pins_test,
	input wire prog_mode,
	input wire store_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tck_q;
	logic rst_q;
	logic [2:0] hi_cnt;
	// count test clock rises with mode select high, saturating at seven
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tck_q <= 1'b0;
			rst_q <= 1'b1;
			hi_cnt <= 3'h0;
		end else begin
			tck_q <= tck;
			rst_q <= 1'b0;
			if (tck && !tck_q)
				hi_cnt <= !tms ? 3'h0 : hi_cnt + {2'h0, hi_cnt != 3'h7};
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	chk_reset_quiet: assert property (
		disable iff (1'b0)
		rst && rst_q |-> tdo_oe_n_reg && !prog_mode && !tdo_reg)
		else $error("outputs not quiet in reset");
	chk_tms_reset: assert property (hi_cnt >= 3'h5 |-> ##3
		(tdo_oe_n_reg && !prog_mode && !pins_test))
		else $error("mode select high did not reset");
	chk_tdo_fall: assert property ($changed(tdo_reg) |-> !tck)
		else $error("data out moved while test clock high");
	chk_busy_pen: assert property ($rose(store_busy) |->
		prog_mode)
		else $error("store ran outside programming mode");
	chk_busy_len: assert property ($rose(store_busy) |->
		store_busy [*7] ##[1:3] !store_busy)
		else $error("store operation length wrong");
	chk_busy_idle: assert property ($rose(store_busy) |->
		tdo_oe_n_reg)
		else $error("store started during a shift");
	chk_pins_upd: assert property ($changed(pins_out) |->
		tdo_oe_n_reg)
		else $error("pin latch moved during a shift");
	chk_mode_upd: assert property ($changed(prog_mode) |->
		tdo_oe_n_reg)
		else $error("programming mode moved during a shift");
	cover property ($rose(store_busy));
	cover property ($fell(tdo_oe_n_reg));
	cover property ($rose(pins_test));
endmodule
bind jtp_tap jtp_tap_chk i_jtp_tap_chk (.clk(clk), .rst(rst), .tck(tck),
	.tms(tms), .tdi(tdi), .tdo_reg(tdo_reg), .tdo_oe_n_reg(tdo_oe_n_reg),
	.pins_in(pins_in), .pins_out(pins_out), .pins_test(pins_test),
	.prog_mode(prog_mode), .store_busy(store_busy));
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the test access port
`default_nettype none
`include "jtp_map.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] IDC = 32'h5A3C0F01; // arbitrary value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic tck, tms, tdi;
	logic [`JTP_BSR_W-1:0] pins_in = 8'h00;
	wire tdo, oe_n, pins_test, prog_mode, busy;
	wire [`JTP_BSR_W-1:0] pins_out;
	int failures = 0, checks = 0, cycles = 0, ops = 0, exp_ops = 0, lock = 0;
	logic [31:0] rnd = 32'h309C;
	logic [127:0] q, col;
	jtp_tap #(.IDENT_CODE(IDC)) i_jtp_tap (.clk(clk), .rst(rst), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo_reg(tdo), .tdo_oe_n_reg(oe_n),
		.pins_in(pins_in), .pins_out(pins_out), .pins_test(pins_test),
		.prog_mode(prog_mode), .store_busy(busy));
	jtp_host host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	always #20 clk = ~clk;
	// count store operations seen and cut a hang short
	always @(posedge clk) begin
		cycles++;
		if ($rose(busy))
			ops++;
		if (cycles == 40000) begin
			failures++;
			tally_and_finish();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic cmp_scan(input string n, input logic [127:0] e, g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp_pin(input string n, input logic [7:0] e, g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic ir(input logic [7:0] op);
		host.scan(1'b1, 8, -1, {120'h0, op}, q);
		cmp_scan("ir capture", 128'h16, q);
	endtask
	task automatic dr(input int n, input logic [127:0] d, e);
		host.scan(1'b0, n, -1, d, q);
		cmp_scan("data scan", e, q);
	endtask
	// store instruction; run says whether the device should act on it
	task automatic store(input logic [7:0] c, input int run);
		ir(c);
		host.idle(3);
		exp_ops += run;
		if (run && c == `JTP_OP_PROG_LOCK)
			lock = 1;
		if (run && c == `JTP_OP_ERASE)
			lock = 0;
	endtask
	task automatic put_col();
		ir(`JTP_OP_ADDR);
		host.scan(1'b0, 10, -1, 128'h5, q);
		ir(`JTP_OP_DATA);
		host.scan(1'b0, 90, -1, col, q);
		store(`JTP_OP_PROG, 1);
	endtask
	// locked columns read back as zero
	task automatic get_col();
		store(`JTP_OP_VERIFY, 1);
		ir(`JTP_OP_DATA);
		dr(90, 128'h0, lock ? 128'h0 : col);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		host.idle(1);
		host.scan(1'b0, 32, 9, 128'h0, q);
		cmp_scan("ident", {96'h0, IDC}, q);
		rnd = lfsr(rnd);
		ir(8'h80 | rnd[7:0]);
		dr(8, rnd[15:8], {rnd[14:8], 1'b0});
		pins_in <= rnd[23:16];
		ir(`JTP_OP_SAMPLE);
		dr(8, 128'h0, rnd[23:16]);
		ir(`JTP_OP_EXTEST);
		dr(8, rnd[31:24], rnd[23:16]);
		cmp_pin("pins out", rnd[31:24], pins_out);
		cmp_pin("test mode", 8'h01, {7'h0, pins_test});
		host.to_reset();
		cmp_pin("test mode", 8'h00, {7'h0, pins_test});
		dr(32, 128'h0, {96'h0, IDC});
		store(`JTP_OP_ERASE, 0);
		cmp_pin("ops", exp_ops[7:0], ops[7:0]);
		store(`JTP_OP_PEN, 0);
		cmp_pin("prog mode", 8'h01, {7'h0, prog_mode});
		store(`JTP_OP_ERASE, 1);
		rnd = lfsr(rnd);
		col = {38'h0, rnd[25:0], ~rnd, rnd};
		put_col();
		get_col();
		store(`JTP_OP_PROG_LOCK, 1);
		get_col();
		ir(`JTP_OP_USIG);
		dr(32, 128'h0, 128'h0);
		rnd = lfsr(rnd);
		ir(`JTP_OP_USIG);
		dr(32, rnd, 128'h0);
		store(`JTP_OP_PROG_USIG, 1);
		ir(`JTP_OP_USIG);
		dr(32, 128'h0, rnd);
		store(`JTP_OP_ERASE, 1);
		put_col();
		get_col();
		cmp_pin("ops", exp_ops[7:0], ops[7:0]);
		host.to_reset();
		cmp_pin("prog mode", 8'h00, {7'h0, prog_mode});
		tally_and_finish();
	end
endmodule
`default_nettype wire
